//--- core/msr_pkg.sv
// Package with register map, field layout and carrier types for redundancy control.
package msr_pkg;

  // ==========================================================================
  // Register byte offsets on the APB bus.
  // ==========================================================================
  localparam logic [7:0] CTRL_OFFSET      = 8'h00; // Pin-overridable controls.
  localparam logic [7:0] BW_OFFSET        = 8'h04; // Main-path bandwidth codes.
  localparam logic [7:0] REMOTE_OFFSET    = 8'h08; // Peer source-valid copy.
  localparam logic [7:0] STATUS_OFFSET    = 8'h0C; // Effective settings, read only.
  localparam logic [7:0] LOCAL_OFFSET     = 8'h10; // Own source-valid status, read only.

  // ==========================================================================
  // Field widths and positions.
  // ==========================================================================
  localparam int unsigned SRC_COUNT       = 14;    // Number of reference inputs.
  localparam int unsigned PRIO_WIDTH      = 4;     // Width of one priority code.
  localparam int unsigned BW_WIDTH        = 5;     // Width of one bandwidth code.
  localparam int unsigned CTRL_PRIO_LSB   = 0;     // Cross-connect priority field.
  localparam int unsigned CTRL_PBO_BIT    = 4;     // Phase hit absorption enable.
  localparam int unsigned CTRL_REV_BIT    = 5;     // Revertive switching enable.
  localparam int unsigned CTRL_MAN_BIT    = 6;     // Manual bandwidth selection.
  localparam int unsigned CTRL_MACQ_BIT   = 7;     // Manual choice: acquisition bandwidth.
  localparam int unsigned CTRL_AUXL_BIT   = 8;     // Auxiliary path locked to main path.
  localparam int unsigned BW_LOCK_LSB     = 0;     // Locked bandwidth field.
  localparam int unsigned BW_ACQ_LSB      = 8;     // Acquisition bandwidth field.

  // ==========================================================================
  // Fixed codes and reset values.
  // ==========================================================================
  localparam logic [3:0]  CROSS_INPUT_IDX = 4'hB;  // Cross-connect input number (11).
  localparam logic [3:0]  SLAVE_PRIO      = 4'h1;  // Highest priority forced on a slave.
  localparam logic [3:0]  PRIO_RESET      = 4'h0;  // Cross-connect input disabled.
  localparam logic [4:0]  BW_LOCK_RESET   = 5'h04; // Default locked bandwidth code.
  localparam logic [4:0]  BW_ACQ_RESET    = 5'h0A; // Default acquisition bandwidth code.
  localparam logic [13:0] REMOTE_RESET    = 14'h3FFF; // Peer reports all inputs valid.

  // ==========================================================================
  // Carrier types.
  // ==========================================================================
  // Software controls that the role select pin may override.
  typedef struct packed {
    logic       aux_lock_main;
    logic       manual_acq;
    logic       bw_manual;
    logic       revertive_en;
    logic       pbo_en;
    logic [3:0] cross_prio;
  } msr_ctrl_type;

  // Settings actually applied to the timing paths.
  typedef struct packed {
    logic       aux_align;
    logic       revertive_en;
    logic       pbo_en;
    logic [4:0] main_bw;
    logic [3:0] cross_prio;
  } msr_eff_type;

  localparam msr_ctrl_type CTRL_RESET = '{aux_lock_main: 1'b0, manual_acq: 1'b0,
                                         bw_manual: 1'b0, revertive_en: 1'b0,
                                         pbo_en: 1'b0, cross_prio: PRIO_RESET};

endpackage

//--- core/msr_redundancy.sv
// Master/slave redundancy control with APB register access.
//
// How it works
// RULE1 - Slave forces cross-connect input priority to one.
// RULE2 - Slave disables phase hit absorption.
// RULE3 - Slave forces revertive switching on.
// RULE4 - Slave uses acquisition bandwidth for main path.
// RULE5 - Master takes priority, absorption, revertive from registers.
// RULE6 - Master bandwidth automatic or manual per register.
// RULE7 - Software disables cross-connect input on master.
// RULE8 - Overridden functions remain software controllable.
// RULE9 - Software keeps source priorities equal in both.
// RULE10 - Software copies peer source-valid into remote register.
// RULE11 - Software enables revertive mode.
// RULE12 - Software sets slave bandwidth above master.
// RULE13 - Software polls to keep settings aligned.
// RULE14 - Locked slave follows master frequency exactly.
// RULE15 - Auxiliary outputs aligned only when locked to main.
// RULE16 - Inputs invalid at peer are treated invalid.
// RULE17 - Role pin synchronised, applied without reset.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
module msr_redundancy (
  // Clock and reset.
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave port.
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic      [31:0]          prdata,
  output logic                      pslverr,
  // Role select pin, high for master, low for slave.
  input  wire logic                 role_select_pin,
  // Main timing path status from the same clock domain.
  input  wire logic                 main_dpll_locked,
  input  wire logic [3:0]           main_selected_input,
  input  wire logic [13:0]          local_sources_valid,
  // Settings applied to the timing paths.
  output logic                      role_is_master,
  output msr_pkg::msr_eff_type      eff_settings,
  output logic      [13:0]          eff_sources_valid,
  output logic                      tracking_master
);

  // ==========================================================================
  // Storage and synchronised pin.
  // ==========================================================================
  msr_pkg::msr_ctrl_type ctrl;          // Software control register.
  logic [4:0]            bw_locked;     // Locked bandwidth code.
  logic [4:0]            bw_acq;        // Acquisition bandwidth code.
  logic [13:0]           remote_valid;  // Peer source-valid copy.
  logic                  role_sync;     // Synchronised role pin.

  // Role pin passes two flip-flops before any logic reads it.
  msr_sync #(
    .WIDTH    (1)
  ) u_role_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (role_select_pin),
    .sync_out (role_sync)
  );

  // ==========================================================================
  // APB decode.
  // ==========================================================================
  logic        access;       // Access phase in progress.
  logic        wr_commit;    // Write takes effect on this edge.
  logic        hit_ctrl;     // Address decodes.
  logic        hit_bw;
  logic        hit_remote;
  logic        hit_status;
  logic        hit_local;
  logic        mapped;       // Any known register.
  logic [31:0] rd_mux;       // Read data selected by address.
  logic [31:0] status_word;  // Effective settings as read by software.

  assign access     = psel & penable;
  assign wr_commit  = access & pready & pwrite & mapped;
  assign hit_ctrl   = (paddr == msr_pkg::CTRL_OFFSET);
  assign hit_bw     = (paddr == msr_pkg::BW_OFFSET);
  assign hit_remote = (paddr == msr_pkg::REMOTE_OFFSET);
  assign hit_status = (paddr == msr_pkg::STATUS_OFFSET);
  assign hit_local  = (paddr == msr_pkg::LOCAL_OFFSET);
  assign mapped     = hit_ctrl | hit_bw | hit_remote | hit_status | hit_local;

  // Status word packs the role and tracking bits above the applied settings.
  assign status_word = {18'h00000, tracking_master, role_is_master, eff_settings};

  // Read multiplexer; unmapped addresses read as zero.
  assign rd_mux = hit_ctrl   ? {23'h000000, ctrl} :
                  hit_bw     ? {19'h00000, bw_acq, 3'h0, bw_locked} :
                  hit_remote ? {18'h00000, remote_valid} :
                  hit_status ? status_word :
                  hit_local  ? {18'h00000, local_sources_valid} :
                  32'h00000000;

  // One wait state: pready rises in the second access cycle and drops after.
  logic next_pready;
  assign next_pready = access & ~pready;

  // Bus answer flops, loaded together so data and error line up with pready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_pready;
      prdata  <= (next_pready & ~pwrite) ? rd_mux : 32'h00000000;
      pslverr <= next_pready & ~mapped;
    end
  end

  // ==========================================================================
  // Register writes.
  // ==========================================================================
  // Registers keep their stored values in both roles, so software still owns
  // every overridden function once the pin releases it. Read-only offsets
  // accept the write cycle and change nothing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl         <= msr_pkg::CTRL_RESET;
      bw_locked    <= msr_pkg::BW_LOCK_RESET;
      bw_acq       <= msr_pkg::BW_ACQ_RESET;
      remote_valid <= msr_pkg::REMOTE_RESET;
    end else begin
      if (wr_commit && hit_ctrl) begin // [RULE8]
        ctrl <= msr_pkg::msr_ctrl_type'(pwdata[8:0]);
      end
      if (wr_commit && hit_bw) begin
        bw_locked <= pwdata[msr_pkg::BW_LOCK_LSB +: 5];
        bw_acq    <= pwdata[msr_pkg::BW_ACQ_LSB +: 5];
      end
      if (wr_commit && hit_remote) begin // [RULE16]
        remote_valid <= pwdata[13:0];
      end
    end
  end

  // ==========================================================================
  // Role overrides.
  // ==========================================================================
  logic                 use_acq;           // Master picks acquisition bandwidth.
  msr_pkg::msr_eff_type next_eff;          // Settings for the next cycle.
  logic [13:0]          next_valid;        // Combined source validity.
  logic                 next_tracking;     // Slave locked on the master-fed input.

  // Automatic mode uses acquisition bandwidth until the loop reports lock.
  assign use_acq = ctrl.bw_manual ? ctrl.manual_acq : ~main_dpll_locked; // [RULE6]

  // Slave forces fixed values; master passes the registers through.
  assign next_eff.cross_prio   = role_sync ? ctrl.cross_prio
                                           : msr_pkg::SLAVE_PRIO; // [RULE1] [RULE5]
  assign next_eff.pbo_en       = role_sync & ctrl.pbo_en;          // [RULE2] [RULE5]
  assign next_eff.revertive_en = ~role_sync | ctrl.revertive_en;   // [RULE3] [RULE5]
  assign next_eff.main_bw      = (~role_sync | use_acq) ? bw_acq
                                                        : bw_locked; // [RULE4] [RULE6]
  assign next_eff.aux_align    = ctrl.aux_lock_main;               // [RULE15]

  // An input counts as valid only where both devices see it valid.
  assign next_valid = local_sources_valid & remote_valid; // [RULE16]

  // Slave locked to the cross-connect input reproduces the master frequency.
  assign next_tracking = ~role_sync & main_dpll_locked
                       & (main_selected_input == msr_pkg::CROSS_INPUT_IDX); // [RULE14]

  // Applied settings follow the synchronised pin every cycle, no reset needed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      role_is_master    <= 1'b0;
      eff_settings      <= '0;
      eff_sources_valid <= 14'h0000;
      tracking_master   <= 1'b0;
    end else begin
      role_is_master    <= role_sync; // [RULE17]
      eff_settings      <= next_eff;
      eff_sources_valid <= next_valid;
      tracking_master   <= next_tracking;
    end
  end

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Pin edge reaches the applied role within three clocks.
  sequence s_pin_rise;
    $rose(role_select_pin);
  endsequence
  sequence s_role_up;
    ##[2:3] role_is_master;
  endsequence

  a_role_pin_sync: assert property ( // [RULE17]
    s_pin_rise ##1 role_select_pin [*2] |-> s_role_up)
    else $error("Role pin not applied within three clocks");

  // Outputs still hold reset zeros at the first edge after release, so skip it.
  a_slave_prio_forced: assert property ( // [RULE1]
    $past(presetn) && !role_is_master && !$past(role_sync)
      |-> eff_settings.cross_prio == msr_pkg::SLAVE_PRIO)
    else $error("Slave cross-connect priority not forced to one");

  a_slave_pbo_off: assert property ( // [RULE2]
    $past(!role_sync) |-> !eff_settings.pbo_en)
    else $error("Phase hit absorption active on slave");

  a_slave_revert_on: assert property ( // [RULE3]
    $past(presetn) && $past(!role_sync)
      |-> eff_settings.revertive_en)
    else $error("Revertive switching off on slave");

  a_slave_acq_bw: assert property ( // [RULE4]
    $past(presetn) && $past(!role_sync)
      |-> eff_settings.main_bw == $past(bw_acq))
    else $error("Slave bandwidth differs from acquisition setting");

  a_master_from_regs: assert property ( // [RULE5]
    $past(role_sync) |-> eff_settings.cross_prio == $past(ctrl.cross_prio)
                      && eff_settings.pbo_en == $past(ctrl.pbo_en)
                      && eff_settings.revertive_en == $past(ctrl.revertive_en))
    else $error("Master settings do not follow registers");

  a_master_auto_bw: assert property ( // [RULE6]
    $past(role_sync && !ctrl.bw_manual && main_dpll_locked)
      |-> eff_settings.main_bw == $past(bw_locked))
    else $error("Locked master not on locked bandwidth");

  a_regs_kept_slave: assert property ( // [RULE8]
    !role_sync && wr_commit && hit_ctrl |=> ctrl == $past(pwdata[8:0]))
    else $error("Control write lost while pin overrides");

  a_peer_invalid: assert property ( // [RULE16]
    eff_sources_valid != 14'h0000 |-> ($past(remote_valid) & eff_sources_valid)
                                      == eff_sources_valid)
    else $error("Input valid here though invalid at peer");

  a_tracking_slave: assert property ( // [RULE14]
    tracking_master |-> $past(main_dpll_locked) && !role_is_master)
    else $error("Tracking flagged without slave lock");

  a_aux_align: assert property ( // [RULE15]
    eff_settings.aux_align |-> $past(ctrl.aux_lock_main))
    else $error("Auxiliary alignment without lock to main path");

  a_apb_ready_pulse: assert property (
    pready |=> !pready)
    else $error("Ready held longer than one cycle");

  // Setup cycle followed by the first access cycle starts every transfer.
  sequence s_apb_start;
    psel && !penable ##1 psel && penable;
  endsequence
  // One wait state, then ready in the second access cycle.
  sequence s_apb_wait;
    !pready ##1 pready;
  endsequence

  a_apb_wait_state: assert property (
    s_apb_start |-> s_apb_wait)
    else $error("Ready not in second access cycle");

  // Error only accompanies ready, and only for an unmapped address.
  a_apb_err_unmapped: assert property (
    pslverr == (pready && !$past(mapped)))
    else $error("Error response does not match address decode");

  // Read data comes from the register selected in the cycle before ready.
  a_apb_read_data: assert property (
    pready && !pwrite |-> prdata == $past(rd_mux))
    else $error("Read data differs from selected register");

  // A bandwidth write stores both codes at the commit edge in either role.
  a_bw_write: assert property ( // [RULE8]
    wr_commit && hit_bw |=> bw_locked == $past(pwdata[4:0])
                         && bw_acq == $past(pwdata[12:8]))
    else $error("Bandwidth write not stored");

  // A peer validity write stores the copied word at the commit edge.
  a_remote_write: assert property ( // [RULE16]
    wr_commit && hit_remote |=> remote_valid == $past(pwdata[13:0]))
    else $error("Remote validity write not stored");

  // Unlocked master in automatic mode runs on the acquisition bandwidth.
  a_master_acq_bw: assert property ( // [RULE6]
    $past(role_sync && !ctrl.bw_manual && !main_dpll_locked)
      |-> eff_settings.main_bw == $past(bw_acq))
    else $error("Unlocked master not on acquisition bandwidth");

  // Manual mode on a master applies the bandwidth that software chose.
  a_master_manual_bw: assert property ( // [RULE6]
    $past(role_sync && ctrl.bw_manual)
      |-> eff_settings.main_bw == ($past(ctrl.manual_acq) ? $past(bw_acq)
                                                          : $past(bw_locked)))
    else $error("Manual master bandwidth not applied");

  // Applied role is the synchronised pin one clock later.
  a_role_follows: assert property ( // [RULE17]
    role_is_master == $past(role_sync))
    else $error("Applied role does not follow synchroniser");

  // Pin fall returns the block to the slave role without a reset.
  sequence s_pin_fall;
    $fell(role_select_pin);
  endsequence
  sequence s_role_down;
    ##[2:3] !role_is_master;
  endsequence

  a_role_pin_fall: assert property ( // [RULE17]
    s_pin_fall ##1 !role_select_pin [*2] |-> s_role_down)
    else $error("Slave role not applied within three clocks");

  // Tracking is only flagged while the loop uses the cross-connect input.
  a_tracking_input: assert property ( // [RULE14]
    tracking_master |-> $past(main_selected_input) == msr_pkg::CROSS_INPUT_IDX)
    else $error("Tracking flagged on another input");

endmodule

//--- core/msr_sync.sv
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/100ps
module msr_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Asynchronous level in, synchronised level out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // First stage, read only by the second stage.
  logic [WIDTH-1:0] stage1;

  // ==========================================================================
  // Synchroniser stages.
  // ==========================================================================
  // Both stages clear to zero under reset and then follow the input.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

//--- tb/msr_peer_model.sv
// Behavioural model of the peer timing device cross-connected to the block.
`timescale 1ns/100ps
module msr_peer_model (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Role that the peer is asked to take, high for master.
  input  wire logic        peer_master,
  // Source validity seen by the peer's own monitors.
  input  wire logic [13:0] peer_seen,
  // Strap toward the block and the peer's reported validity.
  output logic             role_pin,
  output logic      [13:0] peer_valid
);
  // ==========================================================================
  // Peer state
  // ==========================================================================
  // Only one device may be master, so the block gets the opposite role.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      role_pin   <= 1'b0;
      peer_valid <= 14'h3FFF;
    end else begin
      role_pin   <= ~peer_master;
      peer_valid <= peer_seen;
    end
  end
endmodule

//--- tb/tb_top.sv
// Self-checking testbench for the master/slave redundancy control block.
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", n, e, s); end end
module tb_top;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic                 role_select_pin, main_dpll_locked, role_is_master, tracking_master;
  logic                 peer_master, err;
  logic [3:0]           main_selected_input;
  logic [13:0]          local_sources_valid, eff_sources_valid, peer_seen, peer_valid;
  msr_pkg::msr_eff_type eff_settings, ee;
  int                   mismatches = 0;
  int                   cmp_count = 0;
  logic [8:0]           c;
  logic [12:0]          b;

  msr_redundancy u_msr_redundancy (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .role_select_pin(role_select_pin),
    .main_dpll_locked(main_dpll_locked), .main_selected_input(main_selected_input),
    .local_sources_valid(local_sources_valid), .role_is_master(role_is_master),
    .eff_settings(eff_settings), .eff_sources_valid(eff_sources_valid),
    .tracking_master(tracking_master));
  msr_peer_model u_msr_peer_model (.pclk(pclk), .presetn(presetn),
    .peer_master(peer_master), .peer_seen(peer_seen), .role_pin(role_select_pin),
    .peer_valid(peer_valid));

  // ==========================================================================
  // Clock, verdict and watchdog
  // ==========================================================================
  // The clock toggles every half period of 25 ns.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // The whole run needs under a thousand cycles, so this limit means a hang.
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    stop_test();
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // One APB transfer; the request holds until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) mismatches++;
  endtask
  // Settings that the timing paths should receive.
  function automatic msr_pkg::msr_eff_type exp_eff(input logic m, input logic lk);
    msr_pkg::msr_eff_type e;
    logic                 acq;
    acq            = c[6] ? c[7] : !lk;
    e.aux_align    = c[8];
    e.revertive_en = m ? c[5] : 1'b1;
    e.pbo_en       = m ? c[4] : 1'b0;
    e.main_bw      = (!m || acq) ? b[12:8] : b[4:0];
    e.cross_prio   = m ? c[3:0] : msr_pkg::SLAVE_PRIO;
    return e;
  endfunction
  // Programs controls and bandwidth, then checks outputs and status word.
  task automatic check_all(input logic m, input logic lk, input logic [3:0] sel);
    apb(1'b1, msr_pkg::CTRL_OFFSET, {23'h0, c});
    apb(1'b1, msr_pkg::BW_OFFSET, {19'h0, b});
    apb(1'b1, msr_pkg::REMOTE_OFFSET, {18'h0, peer_valid});
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    ee = exp_eff(m, lk);
    `CHK("role", m, role_is_master)
    `CHK("eff", ee, eff_settings)
    `CHK("valid", local_sources_valid & peer_valid, eff_sources_valid)
    `CHK("track", !m && lk && sel == 4'hB, tracking_master)
    apb(1'b0, msr_pkg::STATUS_OFFSET, 32'h0);
    `CHK("status", {18'h0, (!m && lk && sel == 4'hB), m, ee}, rd)
    `CHK("status err", 1'b0, err)
    apb(1'b0, msr_pkg::LOCAL_OFFSET, 32'h0);
    `CHK("local", {18'h0, local_sources_valid}, rd)
    apb(1'b0, msr_pkg::CTRL_OFFSET, 32'h0);
    `CHK("ctrl", {23'h0, c}, rd)
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    presetn = 1'b0; main_dpll_locked = 1'b0; main_selected_input = 4'h0;
    local_sources_valid = 14'h0; peer_master = 1'b1; peer_seen = 14'h3FFF;
    void'($urandom(32'h52c9));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped address.
    apb(1'b0, msr_pkg::BW_OFFSET, 32'h0);
    `CHK("bw reset", {19'h0, msr_pkg::BW_ACQ_RESET, 3'h0, msr_pkg::BW_LOCK_RESET}, rd)
    apb(1'b0, msr_pkg::REMOTE_OFFSET, 32'h0);
    `CHK("remote reset", {18'h0, msr_pkg::REMOTE_RESET}, rd)
    apb(1'b1, 8'h14, 32'hFFFFFFFF);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    $display("test reset done");
    // Master strap, cross input disabled by software, peer as slave.
    peer_master <= 1'b0;
    c = 9'h020;
    b = 13'h1F04;
    main_dpll_locked <= 1'b1; main_selected_input <= 4'hB;
    check_all(1'b1, 1'b1, 4'hB);
    peer_master <= 1'b1;
    check_all(1'b0, 1'b1, 4'hB);
    main_selected_input <= 4'hA;
    check_all(1'b0, 1'b1, 4'hA);
    $display("test tracking done");
    // Random roles, controls, bandwidths and validity; role flips without reset.
    repeat (24) begin
      c = 9'($urandom);
      b = 13'($urandom) & 13'h1F1F;
      peer_master <= 1'($urandom);
      peer_seen <= 14'($urandom);
      main_dpll_locked <= 1'($urandom);
      main_selected_input <= 4'($urandom_range(9, 12));
      local_sources_valid <= 14'($urandom);
      @(posedge pclk);
      check_all(!peer_master, main_dpll_locked, main_selected_input);
    end
    $display("test random done");
    stop_test();
  end
endmodule
